/* hdl/sgw_pkg.sv */
// Constants and types shared by the segment write guard
package sgw_pkg;
    localparam int ADDR_WIDTH     = 16;
    localparam int SEG_WORDS_LOG2 = 9;   // 512-word segments
    localparam int SEG_COUNT      = 128;
    localparam int SEG_IDX_WIDTH  = 7;
    localparam int MASK_COUNT     = 8;
    localparam int MASK_WIDTH     = 16;
    localparam int MASK_SEL_WIDTH = 3;
    localparam int BIT_SEL_WIDTH  = 4;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    // Fixed vectors per violation category
    localparam logic [15:0] VEC_OVERFLOW = 16'h0040;
    localparam logic [15:0] VEC_WRITE    = 16'h0042;
    localparam logic [15:0] VEC_JUMP     = 16'h0044;
    localparam logic [15:0] VEC_IO       = 16'h0046;
    localparam logic [15:0] VEC_HALT     = 16'h0048;
    localparam logic [15:0] VEC_NONE     = 16'h0000;

    typedef enum logic [2:0] {
        SGW_CAT_NONE,
        SGW_CAT_OVERFLOW,
        SGW_CAT_WRITE,
        SGW_CAT_JUMP,
        SGW_CAT_IO,
        SGW_CAT_HALT
    } sgw_cat_type;

    typedef enum logic [1:0] {
        SGW_IDLE,
        SGW_HOLD,
        SGW_IRQ
    } sgw_state_type;
endpackage

/* hdl/sgw_mask_file.sv */
// Protection mask storage with three combinational lookups
`timescale 1ns/1ns
module sgw_mask_file #(
    parameter int MASKS = sgw_pkg::MASK_COUNT
) (
    input  wire logic                               ref_clk,
    input  wire logic                               rst_n,
    input  wire logic                               wr_en,
    input  wire logic [sgw_pkg::MASK_SEL_WIDTH-1:0] wr_sel,
    input  wire logic [sgw_pkg::MASK_WIDTH-1:0]     wr_data,
    input  wire logic [sgw_pkg::SEG_IDX_WIDTH-1:0]  seg_a,
    input  wire logic [sgw_pkg::SEG_IDX_WIDTH-1:0]  seg_b,
    input  wire logic [sgw_pkg::SEG_IDX_WIDTH-1:0]  seg_c,
    output logic                                    prot_a,
    output logic                                    prot_b,
    output logic                                    prot_c
);
    logic [sgw_pkg::MASK_WIDTH-1:0] masks [MASKS];
    logic [MASKS*sgw_pkg::MASK_WIDTH-1:0] flat;

    // Masks clear on reset, processor loads one word per write
    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < MASKS; i++)
        begin
            if (!rst_n)
                masks[i] <= sgw_pkg::MASK_RESET;
            else if (wr_en && wr_sel == i[sgw_pkg::MASK_SEL_WIDTH-1:0])
                masks[i] <= wr_data;
        end
    end

    // Segment k sits at word k/16, bit k%16
    always_comb
    begin
        for (int i = 0; i < MASKS; i++)
            flat[i*sgw_pkg::MASK_WIDTH +: sgw_pkg::MASK_WIDTH] = masks[i];
    end

    assign prot_a = flat[seg_a];
    assign prot_b = flat[seg_b];
    assign prot_c = flat[seg_c];
endmodule

/* hdl/sgw_guard.sv */
// Segment write guard: checks each instruction against protected segments
// Operation
// RULE1 - Memory splits into 512-word segments, unmarked ones are unprotected
// RULE2 - Eight 16-bit mask registers, written by processor I/O instructions
// RULE3 - Masks together hold one flag for each of 128 segments
// RULE4 - Each instruction checks current, next sequential and operand addresses
// RULE5 - Only code running from an unprotected segment is checked
// RULE6 - Sequential advance into a protected segment is a violation
// RULE7 - Write to a protected segment from unprotected code is a violation
// RULE8 - Jump into a protected segment from unprotected code is a violation
// RULE9 - Any I/O instruction from an unprotected segment is a violation
// RULE10 - Halt executed from an unprotected segment is a violation
// RULE11 - Offending instruction completes, interrupt comes afterwards
// RULE12 - Violating write blocks updates of working registers and memory
// RULE13 - Violating I/O instruction never puts its command on the I/O bus
// RULE14 - After completion processor is interrupted to one of five vectors
// RULE15 - Segment k maps to mask k/16, bit k%16, set means protected
// RULE16 - Each category owns a vector, lowest category wins on collision
// RULE17 - Reset clears all masks and any pending violation
`timescale 1ns/1ns
module sgw_guard #(
    parameter int ADDR_W = sgw_pkg::ADDR_WIDTH
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              instr_valid,
    input  wire logic [ADDR_W-1:0] instr_addr,
    input  wire logic [ADDR_W-1:0] next_addr,
    input  wire logic [ADDR_W-1:0] operand_addr,
    input  wire logic              is_write,
    input  wire logic              is_jump,
    input  wire logic              is_io,
    input  wire logic              is_halt,
    input  wire logic              instr_done,
    input  wire logic              mask_wr,
    input  wire logic [2:0]        mask_sel,
    input  wire logic [15:0]       mask_data,
    input  wire logic              irq_ack,
    output logic                   work_reg_inhibit,
    output logic                   mem_write_inhibit,
    output logic                   io_cmd_inhibit,
    output logic                   guard_irq,
    output logic [15:0]            guard_vector,
    output logic [2:0]             guard_cause
);
    localparam int SH = sgw_pkg::SEG_WORDS_LOG2;

    sgw_pkg::sgw_state_type state;
    sgw_pkg::sgw_state_type next_state;
    sgw_pkg::sgw_cat_type   cat_held;
    sgw_pkg::sgw_cat_type   next_cat;

    wire logic [sgw_pkg::SEG_IDX_WIDTH-1:0] seg_cur;
    wire logic [sgw_pkg::SEG_IDX_WIDTH-1:0] seg_nxt;
    wire logic [sgw_pkg::SEG_IDX_WIDTH-1:0] seg_opr;
    wire logic prot_cur;
    wire logic prot_nxt;
    wire logic prot_opr;
    wire logic checking;
    wire logic viol_ovf;
    wire logic viol_wr;
    wire logic viol_jmp;
    wire logic viol_io;
    wire logic viol_halt;
    wire logic any_viol;

    // RULE1 segment index
    // Upper address bits select the 512-word segment
    assign seg_cur = instr_addr[ADDR_W-1:SH];
    assign seg_nxt = next_addr[ADDR_W-1:SH];
    assign seg_opr = operand_addr[ADDR_W-1:SH];

    // RULE2 mask storage
    // RULE3 128 segment flags
    // RULE15 flag lookup
    sgw_mask_file #(
        .MASKS (sgw_pkg::MASK_COUNT)
    ) u_masks (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (mask_wr && !viol_io),
        .wr_sel  (mask_sel),
        .wr_data (mask_data),
        .seg_a   (seg_cur),
        .seg_b   (seg_nxt),
        .seg_c   (seg_opr),
        .prot_a  (prot_cur),
        .prot_b  (prot_nxt),
        .prot_c  (prot_opr)
    );

    // RULE5 unprotected only
    // RULE4 three addresses
    assign checking  = instr_valid && !prot_cur;
    // RULE6 sequential overflow
    assign viol_ovf  = checking && !is_jump && prot_nxt;
    // RULE7 protected write
    assign viol_wr   = checking && is_write && prot_opr;
    // RULE8 protected jump
    assign viol_jmp  = checking && is_jump && prot_opr;
    // RULE9 unprotected I/O
    assign viol_io   = checking && is_io;
    // RULE10 unprotected halt
    assign viol_halt = checking && is_halt;
    assign any_viol  = viol_ovf || viol_wr || viol_jmp || viol_io || viol_halt;

    // RULE16 category priority
    sgw_pkg::sgw_cat_type cat_now;
    assign cat_now = viol_ovf  ? sgw_pkg::SGW_CAT_OVERFLOW :
                     viol_wr   ? sgw_pkg::SGW_CAT_WRITE :
                     viol_jmp  ? sgw_pkg::SGW_CAT_JUMP :
                     viol_io   ? sgw_pkg::SGW_CAT_IO :
                     viol_halt ? sgw_pkg::SGW_CAT_HALT : sgw_pkg::SGW_CAT_NONE;

    // Vector chosen from the held category
    logic [15:0] next_vector;
    always_comb
    begin
        case (next_cat)
            sgw_pkg::SGW_CAT_OVERFLOW: next_vector = sgw_pkg::VEC_OVERFLOW;
            sgw_pkg::SGW_CAT_WRITE:    next_vector = sgw_pkg::VEC_WRITE;
            sgw_pkg::SGW_CAT_JUMP:     next_vector = sgw_pkg::VEC_JUMP;
            sgw_pkg::SGW_CAT_IO:       next_vector = sgw_pkg::VEC_IO;
            sgw_pkg::SGW_CAT_HALT:     next_vector = sgw_pkg::VEC_HALT;
            default:                   next_vector = sgw_pkg::VEC_NONE;
        endcase
    end

    // RULE11 complete then interrupt
    // Violation is latched, instruction runs on until done, then the interrupt rises
    always_comb
    begin
        next_state = state;
        next_cat   = cat_held;
        case (state)
            sgw_pkg::SGW_IDLE:
            begin
                if (any_viol)
                begin
                    next_cat   = cat_now;
                    next_state = instr_done ? sgw_pkg::SGW_IRQ : sgw_pkg::SGW_HOLD;
                end
            end
            sgw_pkg::SGW_HOLD:
            begin
                if (instr_done)
                    next_state = sgw_pkg::SGW_IRQ;
            end
            sgw_pkg::SGW_IRQ:
            begin
                if (irq_ack)
                begin
                    next_state = sgw_pkg::SGW_IDLE;
                    next_cat   = sgw_pkg::SGW_CAT_NONE;
                end
            end
            default:
            begin
                next_state = sgw_pkg::SGW_IDLE;
                next_cat   = sgw_pkg::SGW_CAT_NONE;
            end
        endcase
    end

    // RULE12 write inhibit
    // RULE13 I/O inhibit
    // Inhibits are registered from the violation, so they rise the cycle after it is seen and hold while in SGW_HOLD
    wire logic next_wr_inh;
    wire logic next_io_inh;
    wire logic hold_next;
    assign hold_next   = (next_state == sgw_pkg::SGW_HOLD);
    assign next_wr_inh = (any_viol && state == sgw_pkg::SGW_IDLE && is_write) ||
                         (hold_next && work_reg_inhibit);
    assign next_io_inh = (any_viol && state == sgw_pkg::SGW_IDLE && is_io) ||
                         (hold_next && io_cmd_inhibit);

    // RULE17 reset clears pending
    // RULE14 interrupt to vector
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state             <= sgw_pkg::SGW_IDLE;
            cat_held          <= sgw_pkg::SGW_CAT_NONE;
            guard_irq         <= 1'b0;
            guard_vector      <= sgw_pkg::VEC_NONE;
            guard_cause       <= 3'h0;
            work_reg_inhibit  <= 1'b0;
            mem_write_inhibit <= 1'b0;
            io_cmd_inhibit    <= 1'b0;
        end
        else
        begin
            state             <= next_state;
            cat_held          <= next_cat;
            guard_irq         <= (next_state == sgw_pkg::SGW_IRQ);
            guard_vector      <= next_vector;
            guard_cause       <= next_cat;
            work_reg_inhibit  <= next_wr_inh;
            mem_write_inhibit <= next_wr_inh;
            io_cmd_inhibit    <= next_io_inh;
        end
    end

    // Checks
    sequence s_viol_done;
        state == sgw_pkg::SGW_IDLE && any_viol && instr_done;
    endsequence

    // RULE11 irq after done
    chk_irq_after_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_viol_done |=> guard_irq)
        else $error("interrupt missing after violating instruction");

    // RULE5 protected code clean
    chk_protected_clean: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == sgw_pkg::SGW_IDLE && prot_cur) |=> !guard_irq)
        else $error("interrupt raised from protected code");

    // RULE9 io flagged
    chk_io_flagged: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == sgw_pkg::SGW_IDLE && instr_valid && !prot_cur && is_io
         && !prot_nxt && !is_write) |=> io_cmd_inhibit)
        else $error("I/O from unprotected code not inhibited");

    // RULE12 write blocked
    chk_write_blocked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == sgw_pkg::SGW_IDLE && viol_wr && !instr_done)
        |=> work_reg_inhibit && mem_write_inhibit)
        else $error("violating write not inhibited");

    // RULE16 overflow first
    chk_overflow_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == sgw_pkg::SGW_IDLE && viol_ovf) |=> guard_cause == 3'h1)
        else $error("overflow did not take priority");

    // RULE14 vector matches
    chk_vector_match: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (guard_irq && guard_cause == 3'h5) |-> guard_vector == sgw_pkg::VEC_HALT)
        else $error("halt vector wrong");

    // RULE10 halt flagged
    chk_halt_flagged: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state == sgw_pkg::SGW_IDLE && checking && is_halt && instr_done) |=> guard_irq)
        else $error("halt from unprotected code not flagged");

    // RULE14 irq holds until ack
    chk_irq_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (guard_irq && !irq_ack) |=> guard_irq && $stable(guard_vector))
        else $error("interrupt dropped before acknowledge");
endmodule

/* bench/sgw_cpu_model.sv */
// Processor model: one- or two-cycle instructions, mask loads, interrupt entry
`timescale 1ns/1ns
module sgw_cpu_model (
    input  wire logic       ref_clk,
    input  wire logic       go,
    input  wire logic       one_cycle,
    input  wire logic       wr_req,
    input  wire logic [3:0] ack_delay,
    input  wire logic       guard_irq,
    output logic            instr_valid,
    output logic            instr_done,
    output logic            mask_wr,
    output logic            irq_ack,
    output logic            busy
);
    logic [2:0] step;
    logic [3:0] wait_cnt;

    // Known idle state from time zero
    initial
    begin
        {instr_valid, instr_done, mask_wr, irq_ack, step, wait_cnt} = '0;
    end

    assign busy = (step != 3'h0);

    // Falling edge sequencer keeps clear of the guard's sampling edge
    always @(negedge ref_clk)
    begin
        irq_ack <= 1'b0;
        mask_wr <= wr_req && (step == 3'h0);
        case (step)
            3'h0:
            begin
                // Single-cycle instructions finish in the cycle they start
                instr_valid <= go;
                instr_done  <= go && one_cycle;
                step        <= go ? (one_cycle ? 3'h2 : 3'h1) : 3'h0;
            end
            3'h1:
            begin
                instr_done <= 1'b1;
                step       <= 3'h2;
            end
            3'h2:
            begin
                instr_valid <= 1'b0;
                instr_done  <= 1'b0;
                wait_cnt    <= 4'h0;
                step        <= 3'h3;
            end
            3'h3:
            begin
                // Slow acknowledge on request; give up if no interrupt comes
                wait_cnt <= wait_cnt + 4'h1;
                if (guard_irq && wait_cnt >= ack_delay)
                begin
                    irq_ack <= 1'b1;
                    step    <= 3'h4;
                end
                else if (!guard_irq && wait_cnt == 4'hF)
                    step <= 3'h0;
            end
            default: step <= 3'h0;
        endcase
    end
endmodule

/* bench/segment_write_guard_tb.sv */
// Self-checking bench for the segment write guard
`timescale 1ns/1ns
module segment_write_guard_tb;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        go = 1'b0;
    logic        one_cycle = 1'b0;
    logic        wr_req = 1'b0;
    logic [3:0]  ack_delay = 4'h0;
    logic [15:0] instr_addr = 16'h0000;
    logic [15:0] next_addr = 16'h0000;
    logic [15:0] operand_addr = 16'h0000;
    logic [3:0]  cls = 4'h0;
    logic [2:0]  mask_sel = 3'h0;
    logic [15:0] mask_data = 16'h0000;
    logic        instr_valid, instr_done, irq_ack, busy, mask_wr;
    logic        work_reg_inhibit, mem_write_inhibit, io_cmd_inhibit, guard_irq;
    logic [15:0] guard_vector;
    logic [2:0]  guard_cause;
    logic [2:0]  cause;
    logic [15:0] shadow [8];
    int          miscompares = 0;
    int          tests_run = 0;
    int          seed = 32'h7460f5e9;

    always #25 ref_clk = ~ref_clk;

    sgw_guard u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_addr(instr_addr), .next_addr(next_addr), .operand_addr(operand_addr),
        .is_write(cls[3]), .is_jump(cls[2]), .is_io(cls[1]), .is_halt(cls[0]),
        .instr_done(instr_done), .mask_wr(mask_wr), .mask_sel(mask_sel),
        .mask_data(mask_data), .irq_ack(irq_ack), .work_reg_inhibit(work_reg_inhibit),
        .mem_write_inhibit(mem_write_inhibit), .io_cmd_inhibit(io_cmd_inhibit),
        .guard_irq(guard_irq), .guard_vector(guard_vector), .guard_cause(guard_cause));

    sgw_cpu_model u_cpu (.ref_clk(ref_clk), .go(go), .one_cycle(one_cycle), .wr_req(wr_req),
        .ack_delay(ack_delay), .guard_irq(guard_irq), .instr_valid(instr_valid),
        .instr_done(instr_done), .mask_wr(mask_wr), .irq_ack(irq_ack), .busy(busy));

    function automatic logic prot(input logic [15:0] a);
        return shadow[a[15:13]][a[12:9]];
    endfunction

    function automatic logic [2:0] exp_cause();
        if (prot(instr_addr)) return 3'h0;
        if (prot(next_addr) && !cls[2]) return 3'h1;
        if (cls[3] && prot(operand_addr)) return 3'h2;
        if (cls[2] && prot(operand_addr)) return 3'h3;
        if (cls[1]) return 3'h4;
        if (cls[0]) return 3'h5;
        return 3'h0;
    endfunction

    function automatic logic [15:0] exp_vec(input logic [2:0] c);
        case (c)
            3'h1: return sgw_pkg::VEC_OVERFLOW;
            3'h2: return sgw_pkg::VEC_WRITE;
            3'h3: return sgw_pkg::VEC_JUMP;
            3'h4: return sgw_pkg::VEC_IO;
            3'h5: return sgw_pkg::VEC_HALT;
            default: return sgw_pkg::VEC_NONE;
        endcase
    endfunction

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Load masks only while no instruction runs; shadow follows
    task automatic write_mask(input logic [2:0] sel, input logic [15:0] data);
        mask_sel  = sel;
        mask_data = data;
        wr_req   <= 1'b1;
        @(negedge ref_clk);
        wr_req <= 1'b0;
        repeat (2) @(negedge ref_clk);
        shadow[sel] = data;
    endtask

    // One instruction: inhibits in its body, interrupt after its last cycle
    task automatic run_instr();
        int n;
        cause = exp_cause();
        go        <= 1'b1;
        one_cycle <= 1'($random(seed));
        ack_delay <= 4'($random(seed));
        @(negedge ref_clk);
        go <= 1'b0;
        // Inhibits stand only while the instruction runs
        @(negedge ref_clk);
        check("work_reg_inhibit", work_reg_inhibit, (cause != 3'h0) && cls[3]);
        check("mem_write_inhibit", mem_write_inhibit, (cause != 3'h0) && cls[3]);
        check("io_cmd_inhibit", io_cmd_inhibit, (cause != 3'h0) && cls[1]);
        @(negedge ref_clk);
        check("guard_irq", guard_irq, cause != 3'h0);
        check("guard_vector", guard_vector, exp_vec(cause));
        check("guard_cause", guard_cause, cause);
        check("inhibits after done", {io_cmd_inhibit, mem_write_inhibit}, 16'h0000);
        n = 0;
        while (busy && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (busy)
        begin
            miscompares++;
            report_and_stop();
        end
        else
            check("after ack", {guard_irq, guard_cause}, 16'h0000);
    endtask

    // Sequential neighbours often straddle a segment boundary
    task automatic rand_instr();
        logic [31:0] r;
        r            = $random(seed);
        instr_addr   = r[15:0];
        if (r[16])
            instr_addr[8:0] = 9'h1FF;
        next_addr    = instr_addr + 16'h0001;
        r            = $random(seed);
        operand_addr = r[15:0];
        cls          = r[19:16];
        run_instr();
    endtask

    // Main sequence
    initial
    begin
        foreach (shadow[i])
            shadow[i] = 16'h0000;
        repeat (12) @(negedge ref_clk);
        check("reset flags", {work_reg_inhibit, mem_write_inhibit, io_cmd_inhibit, guard_irq},
              16'h0000);
        check("reset vector", guard_vector, sgw_pkg::VEC_NONE);
        rst_n = 1'b1;
        @(negedge ref_clk);
        cls = 4'h1;
        run_instr();
        $display("reset test done");
        for (int i = 0; i < 8; i++)
            write_mask(3'(i), 16'($random(seed)));
        write_mask(3'h7, 16'hFFFF);
        for (int i = 0; i < 300; i++)
        begin
            if (i % 50 == 49)
                write_mask(3'($random(seed)), 16'($random(seed)));
            rand_instr();
        end
        $display("random test done");
        rst_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        rst_n = 1'b1;
        foreach (shadow[i])
            shadow[i] = 16'h0000;
        @(negedge ref_clk);
        repeat (20) rand_instr();
        $display("second reset test done");
        report_and_stop();
    end
endmodule
